// ===== aocr_pkg.sv
// package: offsets, field layout, reset values and decode types for the output config bank
package aocr_pkg;

  localparam logic [7:0] AOCR_CONFIG_OFFSET   = 8'h06;
  localparam logic [7:0] AOCR_RESERVED_OFFSET = 8'h07;

  localparam int AOCR_TOPO_BIT      = 7;
  localparam int AOCR_RATE_LSB      = 4;
  localparam int AOCR_GAIN_LSB      = 2;
  localparam int AOCR_CHSEL_BIT     = 1;
  localparam int AOCR_RSVD_BIT      = 0;

  localparam logic       AOCR_TOPO_RESET  = 1'b0;
  localparam logic [2:0] AOCR_RATE_RESET  = 3'h5;
  localparam logic [1:0] AOCR_GAIN_RESET  = 2'h0;
  localparam logic       AOCR_CHSEL_RESET = 1'b0;
  localparam logic       AOCR_RSVD_RESET  = 1'b1;

  localparam logic [7:0] AOCR_UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    AOCR_GAIN_19P2_DBV,
    AOCR_GAIN_22P6_DBV,
    AOCR_GAIN_25_DBV,
    AOCR_GAIN_RESERVED
  } aocr_gain_e;

  typedef struct packed {
    logic       parallel_bridge_enable;
    logic [2:0] rate_select;
    logic [1:0] gain_code;
    logic       mono_source_channel_select;
    logic       reserved_bit;
  } aocr_config_s;

  typedef struct packed {
    logic       parallel_bridged_mono_output;
    logic       mono_use_left;
    logic [4:0] switching_multiplier;
    logic       double_speed_halved;
    aocr_gain_e gain_setting;
  } aocr_ctrl_s;

endpackage

// ===== aocr_regs.sv
// analog output configuration register bank with decoded amplifier controls
`timescale 1ns/1ps

// Notes on behaviour
// - bit 7 selects topology: 0 bridged stereo, 1 parallel mono; reset 0.
// - bits 6:4 pick switching multiple 6,8,10,12,14,16,20,24 of frame rate; reset 101.
// - in double-speed mode the switching frequency is half the chosen multiple.
// - bits 3:2 analog gain: 00 19.2, 01 22.6, 10 25 dBV; reset 00.
// - bit 1 picks mono source: 0 right, 1 left channel; reset 0.
// - config register sits at offset 0x06, read/write, reads return last written value.
// - double speed means 88.2 or 96 kHz sample rates; it triggers halving.
module aocr_regs
  import aocr_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  output logic [7:0]      reg_rdata_out,
  input  wire logic       double_speed_in,
  output aocr_ctrl_s      ctrl_out
);

  logic         topo_q;
  logic [2:0]   rate_q;
  logic [1:0]   gain_q;
  logic         chsel_q;
  logic         rsvd_q;
  logic         cfg_wr;
  aocr_config_s cfg_view;
  aocr_ctrl_s   ctrl_d;
  logic [7:0]   rdata_d;
  logic         ds_q1;
  logic         ds_q2;
  logic         ds_q3;
  logic         ds_stable_q;

  // multiplier of the frame clock for a rate code
  function automatic logic [4:0] rate_multiple(input logic [2:0] code);
    logic [4:0] m;
    m = 5'h10;
    unique case (code)
      3'h0: m = 5'h06;
      3'h1: m = 5'h08;
      3'h2: m = 5'h0A;
      3'h3: m = 5'h0C;
      3'h4: m = 5'h0E;
      3'h5: m = 5'h10;
      3'h6: m = 5'h14;
      3'h7: m = 5'h18;
    endcase
    return m;
  endfunction

  // one decode of the config offset, shared by write and read
  function automatic logic hits_config(input logic [7:0] addr);
    return addr == AOCR_CONFIG_OFFSET;
  endfunction

  // register image right after reset
  function automatic aocr_config_s reset_image();
    aocr_config_s r;
    r.parallel_bridge_enable     = AOCR_TOPO_RESET;
    r.rate_select                = AOCR_RATE_RESET;
    r.gain_code                  = AOCR_GAIN_RESET;
    r.mono_source_channel_select = AOCR_CHSEL_RESET;
    r.reserved_bit               = AOCR_RSVD_RESET;
    return r;
  endfunction

  // output stage controls from a register image and the speed status
  function automatic aocr_ctrl_s decode_ctrl(input aocr_config_s cfg, input logic halve);
    aocr_ctrl_s c;
    c.parallel_bridged_mono_output = cfg.parallel_bridge_enable;
    // select only matters in mono; stored bit still reads back
    c.mono_use_left                = cfg.parallel_bridge_enable
                                     & cfg.mono_source_channel_select;
    c.switching_multiplier         = rate_multiple(cfg.rate_select);
    // modulator divides by two when this is set
    c.double_speed_halved          = halve;
    // code 11 is forbidden to software; passed on unaltered if written
    c.gain_setting                 = aocr_gain_e'(cfg.gain_code);
    return c;
  endfunction

  // write strobe; writes to any other offset fall away here
  assign cfg_wr = reg_wr_in && hits_config(reg_addr_in);

  // one register per field, so each default is easy to trace
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      topo_q <= AOCR_TOPO_RESET;
    end
    else if (cfg_wr)
    begin
      topo_q <= reg_wdata_in[AOCR_TOPO_BIT];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      rate_q <= AOCR_RATE_RESET;
    end
    else if (cfg_wr)
    begin
      rate_q <= reg_wdata_in[AOCR_RATE_LSB +: 3];
    end
  end

  // code 11 is stored too; keeping away from it is up to software
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      gain_q <= AOCR_GAIN_RESET;
    end
    else if (cfg_wr)
    begin
      gain_q <= reg_wdata_in[AOCR_GAIN_LSB +: 2];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      chsel_q <= AOCR_CHSEL_RESET;
    end
    else if (cfg_wr)
    begin
      chsel_q <= reg_wdata_in[AOCR_CHSEL_BIT];
    end
  end

  // reserved bit stored as written so read-modify-write returns it
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      rsvd_q <= AOCR_RSVD_RESET;
    end
    else if (cfg_wr)
    begin
      rsvd_q <= reg_wdata_in[AOCR_RSVD_BIT];
    end
  end

  // register image as software sees it
  always_comb
  begin
    cfg_view.parallel_bridge_enable     = topo_q;
    cfg_view.rate_select                = rate_q;
    cfg_view.gain_code                  = gain_q;
    cfg_view.mono_source_channel_select = chsel_q;
    cfg_view.reserved_bit               = rsvd_q;
  end

  // double-speed strap is asynchronous; three stages, change taken when last two agree
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ds_q1       <= 1'b0;
      ds_q2       <= 1'b0;
      ds_q3       <= 1'b0;
      ds_stable_q <= 1'b0;
    end
    else
    begin
      ds_q1 <= double_speed_in;
      ds_q2 <= ds_q1;
      ds_q3 <= ds_q2;
      if (ds_q2 == ds_q3)
      begin
        ds_stable_q <= ds_q3;
      end
    end
  end

  // read mux; reserved slot and unmapped offsets read zero, writes there dropped
  always_comb
  begin
    rdata_d = AOCR_UNMAPPED_READ;
    if (hits_config(reg_addr_in))
    begin
      rdata_d = cfg_view;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      reg_rdata_out <= AOCR_UNMAPPED_READ;
    end
    else
    begin
      reg_rdata_out <= rdata_d;
    end
  end

  // decoded controls for the output stage
  always_comb
  begin
    ctrl_d = decode_ctrl(cfg_view, ds_stable_q);
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ctrl_out <= decode_ctrl(reset_image(), 1'b0);
    end
    else
    begin
      ctrl_out <= ctrl_d;
    end
  end

endmodule

// ===== aocr_sva.sv
// checker for the output config bank
`timescale 1ns/1ps
module aocr_sva
  import aocr_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       double_speed_in,
  input wire aocr_ctrl_s ctrl_out
);
  logic [7:0] w_q;
  logic [7:0] p_q;
  logic       r_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // p_q lags one edge, as both registered outputs do
  always_ff @(posedge mclk_in)
  begin
    w_q <= !nrst_in ? 8'h51 : (reg_wr_in && reg_addr_in == 8'h06) ? reg_wdata_in : w_q;
    p_q <= nrst_in ? w_q : 8'h51;
    r_q <= nrst_in && reg_addr_in == 8'h06;
  end
  AST_TOPO: assert property (ctrl_out.parallel_bridged_mono_output == p_q[7])
    else $error("topology");
  AST_RATE: assert property (ctrl_out.switching_multiplier ==
    (p_q[6:4] < 3'h6 ? 5'h6 + {p_q[6:4], 1'b0} : p_q[4] ? 5'h18 : 5'h14)) else $error("rate");
  AST_HALF: assert property (double_speed_in [*7] |-> ctrl_out.double_speed_halved)
    else $error("halving");
  AST_FULL: assert property ((!double_speed_in) [*7] |-> !ctrl_out.double_speed_halved)
    else $error("single speed");
  AST_GAIN: assert property (ctrl_out.gain_setting == aocr_gain_e'(p_q[3:2]))
    else $error("gain");
  AST_MONO: assert property (p_q[7] |-> ctrl_out.mono_use_left == p_q[1])
    else $error("mono source");
  AST_STEREO: assert property (!ctrl_out.parallel_bridged_mono_output |->
    !ctrl_out.mono_use_left) else $error("stereo source");
  AST_READ: assert property (reg_rdata_out == (r_q ? p_q : 8'h00))
    else $error("read data");
endmodule

// ===== aocr_regs_bench.sv
// bench for the output config bank
`timescale 1ns/1ps
module aocr_regs_bench
  import aocr_pkg::*;
;
  logic       mclk_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, double_speed_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, m, c, a;
  aocr_ctrl_s ctrl_out;
  int         errors = 0, checks_done = 0;
  always #2 mclk_in = ~mclk_in;
  localparam logic [7:0] RST_IMAGE = {AOCR_TOPO_RESET, AOCR_RATE_RESET, AOCR_GAIN_RESET,
                                      AOCR_CHSEL_RESET, AOCR_RSVD_RESET};
  aocr_regs i_dut (
    .mclk_in         (mclk_in),
    .nrst_in         (nrst_in),
    .reg_addr_in     (reg_addr_in),
    .reg_wdata_in    (reg_wdata_in),
    .reg_wr_in       (reg_wr_in),
    .reg_rdata_out   (reg_rdata_out),
    .double_speed_in (double_speed_in),
    .ctrl_out        (ctrl_out)
  );
  function automatic logic [9:0] exp_ctrl(logic [7:0] v, logic ds);
    return {v[7], v[7] & v[1], (v[6:4] < 3'h6 ? 5'h6 + {v[6:4], 1'b0} : v[4] ? 5'h18 : 5'h14),
      ds, v[3:2]};
  endfunction
  task automatic chk_read(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_ctrl(string n, logic [9:0] e, logic [9:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // seven idle edges cover the slow double speed sync
  task automatic put(logic [7:0] a, logic [7:0] d, logic w, logic ds);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    double_speed_in <= ds;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    repeat (7) @(posedge mclk_in);
    #1;
  endtask
  initial
  begin
    void'($urandom(32'hFF61));
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    m = RST_IMAGE;
    for (int i = 0; i < 48; i++)
    begin
      if (i == 24)
      begin
        // mid-run reset must bring every field back to its default
        @(posedge mclk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'b1;
        m = RST_IMAGE;
      end
      c = 8'($urandom);
      c = {c[7], i[2:0], (i[4:3] == 2'h3 ? 2'h2 : i[4:3]), c[1], 1'b1};
      if (i < 2)
        c = i[0] ? 8'hFB : 8'h03;
      a = 8'($urandom) | 8'h08;
      put(a, ~c, 1'b1, i[1]);
      chk_read("unmapped", AOCR_UNMAPPED_READ, reg_rdata_out);
      put(AOCR_CONFIG_OFFSET, ~c, 1'b0, i[1]);
      chk_read("rdata", m, reg_rdata_out);
      chk_ctrl("ctrl", exp_ctrl(m, i[1]), ctrl_out);
      put(AOCR_CONFIG_OFFSET, c, 1'b1, i[1]);
      m = c;
    end
    put(AOCR_CONFIG_OFFSET, 8'h00, 1'b0, 1'b0);
    chk_read("last rdata", m, reg_rdata_out);
    chk_ctrl("last ctrl", exp_ctrl(m, 1'b0), ctrl_out);
    test_done();
  end
endmodule
bind aocr_regs aocr_sva i_sva (
  .mclk_in         (mclk_in),
  .nrst_in         (nrst_in),
  .reg_addr_in     (reg_addr_in),
  .reg_wdata_in    (reg_wdata_in),
  .reg_wr_in       (reg_wr_in),
  .reg_rdata_out   (reg_rdata_out),
  .double_speed_in (double_speed_in),
  .ctrl_out        (ctrl_out)
);
